// ---- rtl/fsd_flash_security_decode.sv ----
// flash security byte latch, decode and command parameter index register
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// (R1) backdoor key access allowed only when backdoor field is 10
// (R2) device unsecured only when security field is 10, else secured
// (R3) a successful backdoor unlock forces the security field to 10
// (R4) software should write 01 to the backdoor field to disable it
// (R5) software should write 01 to the security field to secure
// (R6) software should leave reserved bits five to two erased
// (R7) parameter index register at offset 0x0002 holds the index that software writes
// (R8) only the index field is writable; other bits read 0
// (R9) security byte captured around reset; outputs decoded combinationally from it
module fsd_flash_security_decode #(
  parameter int INDEX_W = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fsd_pkg::fsd_byte_t nvm_sec_byte,
  input wire logic backdoor_unlock,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output fsd_pkg::fsd_byte_t reg_rd_data,
  output logic backdoor_enabled,
  output logic secured,
  output logic sec_loaded,
  output logic [INDEX_W-1:0] param_index
);
  import fsd_pkg::*;

  // the index field must fit the byte-wide register port
  if (INDEX_W < 1 || INDEX_W > 8) begin : g_bad_index_w
    $error("INDEX_W must lie between 1 and 8");
  end

  // nonvolatile byte arrives from another domain, so two stages first
  // a whole byte may pass two stages only because it holds still through capture
  fsd_byte_t sync_1_reg;
  fsd_byte_t sync_2_reg;
  logic [1:0] load_cnt_reg;
  logic [1:0] load_cnt_next;
  logic loaded_reg;
  fsd_byte_t stored_reg;
  fsd_byte_t stored_next;
  logic unlocked_reg;
  logic [INDEX_W-1:0] idx_reg;
  logic [INDEX_W-1:0] idx_next;
  fsd_byte_t rd_data_reg;
  fsd_byte_t rd_data_next;

  wire load_now;
  wire fsd_byte_t sec_byte_eff;
  wire dec_key;
  wire dec_sec;
  wire dec_rsv_erased;
  wire hit_sec;
  wire hit_idx;
  wire hit_stat;
  wire idx_write;
  wire fsd_byte_t idx_readback;
  wire fsd_byte_t stat_readback;
  wire fsd_byte_t rd_mux;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_1_reg <= SEC_BYTE_RST;
      sync_2_reg <= SEC_BYTE_RST;
    end else begin
      sync_1_reg <= nvm_sec_byte;
      sync_2_reg <= sync_1_reg;
    end
  end

  // capture waits until the second stage holds a post-reset sample
  assign load_now = !loaded_reg && (load_cnt_reg == LOAD_WAIT); // [R9]
  assign load_cnt_next = (load_cnt_reg == LOAD_WAIT) ? load_cnt_reg : load_cnt_reg + 2'h1;
  assign stored_next = load_now ? sync_2_reg : stored_reg; // [R9]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_cnt_reg <= 2'h0;
      loaded_reg <= 1'b0;
      stored_reg <= SEC_BYTE_RST;
    end else begin
      load_cnt_reg <= load_cnt_next;
      loaded_reg <= loaded_reg | load_now;
      stored_reg <= stored_next;
    end
  end

  // unlock is sticky until reset, so a later capture cannot re-secure
  // success is judged outside; the pulse is not gated by the key field
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlocked_reg <= 1'b0;
    end else if (backdoor_unlock) begin
      unlocked_reg <= 1'b1; // [R3]
    end
  end

  // forcing happens on the decoded view; the stored copy stays as loaded
  assign sec_byte_eff = fsd_apply_unlock(stored_reg, unlocked_reg); // [R3]

  fsd_sec_decode u_decode (
    .sec_byte(sec_byte_eff),
    .backdoor_en(dec_key),
    .secured(dec_sec),
    .rsv_erased(dec_rsv_erased)
  );

  assign backdoor_enabled = dec_key; // [R1] [R9]
  assign secured = dec_sec; // [R2] [R9]
  assign sec_loaded = loaded_reg;

  // register port decode
  assign hit_sec = reg_addr == OFF_SEC_BYTE;
  assign hit_idx = reg_addr == OFF_PARAM_IDX; // [R7]
  assign hit_stat = reg_addr == OFF_STATUS;
  assign idx_write = reg_wr && hit_idx; // [R7]
  // upper write bits are dropped; they have no storage
  assign idx_next = idx_write ? reg_wr_data[INDEX_W-1:0] : idx_reg; // [R8]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_reg <= PARAM_IDX_RST[INDEX_W-1:0];
    end else begin
      idx_reg <= idx_next;
    end
  end

  assign param_index = idx_reg;
  assign idx_readback = fsd_byte_t'(idx_reg); // [R8]
  assign stat_readback = {4'h0, unlocked_reg, loaded_reg, dec_sec, dec_key};
  // unmapped offsets read zero rather than stale data
  assign rd_mux = hit_sec ? sec_byte_eff :
                  hit_idx ? idx_readback :
                  hit_stat ? stat_readback : 8'h00;
  // read data stands only in the cycle after the strobe
  assign rd_data_next = reg_rd ? rd_mux : RD_DATA_RST;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= RD_DATA_RST;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rd_data = rd_data_reg;

  // checks
  localparam int LOAD_LAT_MIN = 1;
  localparam int LOAD_LAT_MAX = 4;

  logic [2:0] rel_cnt_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rel_cnt_reg <= 3'h0;
    end else if (rel_cnt_reg != 3'h7) begin
      rel_cnt_reg <= rel_cnt_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_key_decode;
    backdoor_enabled == (sec_byte_eff[KEY_HI:KEY_LO] == 2'h2);
  endproperty
  a_key_decode: assert property (p_key_decode) else $error("backdoor enable wrong for field value"); // [R1]

  property p_sec_decode;
    secured == (sec_byte_eff[SEC_HI:SEC_LO] != 2'h2);
  endproperty
  a_sec_decode: assert property (p_sec_decode) else $error("secured output wrong for field value"); // [R2]

  property p_unlock_forces;
    backdoor_unlock |=> !secured && sec_byte_eff[SEC_HI:SEC_LO] == 2'h2;
  endproperty
  a_unlock_forces: assert property (p_unlock_forces) else $error("unlock did not open security"); // [R3]

  property p_unlock_holds;
    unlocked_reg |=> unlocked_reg && !secured;
  endproperty
  a_unlock_holds: assert property (p_unlock_holds) else $error("unlocked state was lost"); // [R3]

  property p_idx_write_read;
    reg_wr && reg_addr == 8'h02 ##1 reg_rd && reg_addr == 8'h02 && !reg_wr
      |=> reg_rd_data == fsd_byte_t'($past(reg_wr_data[INDEX_W-1:0], 2));
  endproperty
  a_idx_write_read: assert property (p_idx_write_read) else $error("index readback mismatch"); // [R7]

  property p_idx_upper_zero;
    $past(reg_rd) && $past(reg_addr) == 8'h02 |-> (reg_rd_data >> INDEX_W) == 8'h00;
  endproperty
  a_idx_upper_zero: assert property (p_idx_upper_zero) else $error("index upper bits not zero"); // [R8]

  property p_idx_stable;
    !(reg_wr && reg_addr == 8'h02) |=> $stable(param_index);
  endproperty
  a_idx_stable: assert property (p_idx_stable) else $error("index changed without write"); // [R7]

  property p_load_time;
    $rose(rel_cnt_reg == 3'h1) |-> ##[LOAD_LAT_MIN:LOAD_LAT_MAX] sec_loaded;
  endproperty
  a_load_time: assert property (p_load_time) else $error("security byte not loaded in time"); // [R9]

  property p_load_value;
    $rose(sec_loaded) |-> stored_reg == $past(sync_2_reg);
  endproperty
  a_load_value: assert property (p_load_value) else $error("captured byte differs from sample"); // [R9]

  property p_loaded_frozen;
    sec_loaded |=> $stable(stored_reg);
  endproperty
  a_loaded_frozen: assert property (p_loaded_frozen) else $error("stored byte changed after load"); // [R9]

  property p_rd_one_cycle;
    !reg_rd |=> reg_rd_data == 8'h00;
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("read data outside its cycle"); // [R7]

  // read views, checked against the registers behind them
  property p_idx_rd_view;
    $past(reg_rd) && $past(reg_addr) == OFF_PARAM_IDX |-> reg_rd_data == fsd_byte_t'($past(param_index));
  endproperty
  a_idx_rd_view: assert property (p_idx_rd_view) else $error("index read differs from register"); // [R8]

  property p_sec_rd_view;
    $past(reg_rd) && $past(reg_addr) == OFF_SEC_BYTE |-> reg_rd_data ==
      ($past(unlocked_reg) ? {$past(stored_reg[KEY_HI:RSV_LO]), SEC_UNSECURED} : $past(stored_reg));
  endproperty
  a_sec_rd_view: assert property (p_sec_rd_view) else $error("security byte read view wrong"); // [R3]

  property p_status_rd_view;
    $past(reg_rd) && $past(reg_addr) == OFF_STATUS |->
      reg_rd_data == {4'h0, $past(unlocked_reg), $past(sec_loaded), $past(secured), $past(backdoor_enabled)};
  endproperty
  a_status_rd_view: assert property (p_status_rd_view) else $error("status read view wrong"); // [R1]

  property p_unmapped_rd_zero;
    $past(reg_rd) && $past(reg_addr) != OFF_SEC_BYTE && $past(reg_addr) != OFF_PARAM_IDX &&
      $past(reg_addr) != OFF_STATUS |-> reg_rd_data == 8'h00;
  endproperty
  a_unmapped_rd_zero: assert property (p_unmapped_rd_zero) else $error("unmapped read not zero"); // [R8]

  property p_idx_wr_lands;
    reg_wr && reg_addr == OFF_PARAM_IDX |=> param_index == $past(reg_wr_data[INDEX_W-1:0]);
  endproperty
  a_idx_wr_lands: assert property (p_idx_wr_lands) else $error("index write did not land"); // [R7]

  property p_idx_after_rst;
    rel_cnt_reg == 3'h0 |-> param_index == PARAM_IDX_RST[INDEX_W-1:0];
  endproperty
  a_idx_after_rst: assert property (p_idx_after_rst) else $error("index not at reset value"); // [R7]

  // decoded outputs against the stored byte
  property p_key_from_store;
    backdoor_enabled == (stored_reg[KEY_HI:KEY_LO] == KEY_ENABLED);
  endproperty
  a_key_from_store: assert property (p_key_from_store) else $error("unlock disturbed backdoor field"); // [R3]

  property p_locked_follows_store;
    !unlocked_reg |-> secured == (stored_reg[SEC_HI:SEC_LO] != SEC_UNSECURED);
  endproperty
  a_locked_follows_store: assert property (p_locked_follows_store) else $error("secured not from store"); // [R2]

  property p_preload_secured;
    !sec_loaded && !unlocked_reg |-> secured && !backdoor_enabled;
  endproperty
  a_preload_secured: assert property (p_preload_secured) else $error("open before byte was loaded"); // [R9]

  // capture timing
  property p_sync_two_stages;
    rel_cnt_reg >= 3'h3 |-> sync_2_reg == $past(nvm_sec_byte, 2);
  endproperty
  a_sync_two_stages: assert property (p_sync_two_stages) else $error("sync chain length wrong"); // [R9]

  property p_load_not_early;
    rel_cnt_reg < 3'h3 |-> !sec_loaded;
  endproperty
  a_load_not_early: assert property (p_load_not_early) else $error("byte captured too early"); // [R9]

  property p_loaded_sticky;
    sec_loaded |=> sec_loaded;
  endproperty
  a_loaded_sticky: assert property (p_loaded_sticky) else $error("loaded flag dropped"); // [R9]

  c_unlocked: cover property (sec_loaded && secured ##1 backdoor_unlock ##1 !secured);
  c_key_open: cover property (sec_loaded && backdoor_enabled);
  c_idx_rw: cover property (reg_wr && reg_addr == 8'h02 ##1 reg_rd && reg_addr == 8'h02);
  c_unsecured_load: cover property ($rose(sec_loaded) && !secured);
  c_rsv_erased: cover property (sec_loaded && dec_rsv_erased);

endmodule

// ---- rtl/fsd_pkg.sv ----
// constants and decode functions for the flash security decode block
package fsd_pkg;

  // layout of the security configuration byte
  localparam int SEC_LO = 0;
  localparam int SEC_HI = 1;
  localparam int RSV_LO = 2;
  localparam int RSV_HI = 5;
  localparam int KEY_LO = 6;
  localparam int KEY_HI = 7;

  // field encodings
  localparam logic [1:0] KEY_ENABLED = 2'h2;
  localparam logic [1:0] KEY_PREFERRED_OFF = 2'h1;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] SEC_PREFERRED_ON = 2'h1;

  // value held before the byte is loaded: secured, backdoor closed
  localparam logic [7:0] SEC_BYTE_RST = 8'h00;

  // register offsets on the local port
  localparam logic [7:0] OFF_SEC_BYTE = 8'h01;
  localparam logic [7:0] OFF_PARAM_IDX = 8'h02;
  localparam logic [7:0] OFF_STATUS = 8'h03;

  // status register bit positions
  localparam int STAT_KEY_BIT = 0;
  localparam int STAT_SEC_BIT = 1;
  localparam int STAT_LOADED_BIT = 2;
  localparam int STAT_UNLOCK_BIT = 3;

  // reset values
  localparam logic [7:0] PARAM_IDX_RST = 8'h00;
  localparam logic [7:0] RD_DATA_RST = 8'h00;

  // cycles after reset release before the synchronised byte is valid
  localparam logic [1:0] LOAD_WAIT = 2'h2;

  typedef logic [7:0] fsd_byte_t;

  function automatic logic fsd_key_allowed(input fsd_byte_t b);
    return b[KEY_HI:KEY_LO] == KEY_ENABLED;
  endfunction

  function automatic logic fsd_is_secured(input fsd_byte_t b);
    return b[SEC_HI:SEC_LO] != SEC_UNSECURED;
  endfunction

  // security field forced open once a backdoor unlock has happened
  function automatic fsd_byte_t fsd_apply_unlock(input fsd_byte_t b, input logic unlocked);
    fsd_byte_t r;
    r = b;
    if (unlocked) begin
      r[SEC_HI:SEC_LO] = SEC_UNSECURED;
    end
    return r;
  endfunction

endpackage

// ---- rtl/fsd_sec_decode.sv ----
// combinational decode of the security configuration byte
`timescale 1ns/10ps
module fsd_sec_decode (
  input wire fsd_pkg::fsd_byte_t sec_byte,
  output logic backdoor_en,
  output logic secured,
  output logic rsv_erased
);
  import fsd_pkg::*;

  // only 10 opens the backdoor; 00, 01 and 11 keep it shut
  assign backdoor_en = fsd_key_allowed(sec_byte); // [R1]
  // only 10 is unsecured; every other code reports secured
  assign secured = fsd_is_secured(sec_byte); // [R2]
  // reserved bits are expected erased; reported, never acted on
  assign rsv_erased = &sec_byte[RSV_HI:RSV_LO]; // [R6]

endmodule

// ---- verif/fsd_flash_security_decode_tb_top.sv ----
// self-checking bench for the flash security decode block
`timescale 1ns/10ps
module fsd_flash_security_decode_tb_top;
  import fsd_pkg::*;
  typedef struct packed {
    logic [7:0] sec_byte;
    logic be;
    logic sec;
  } fsd_row_s;
  // index field is three bits wide in this build
  localparam logic [7:0] IMASK = 8'h07;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  fsd_byte_t nvm_sec_byte = 8'h00;
  logic backdoor_unlock = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  fsd_byte_t reg_rd_data;
  logic backdoor_enabled;
  logic secured;
  logic sec_loaded;
  logic [2:0] param_index;
  int miscompares = 0;
  int num_checks = 0;
  fsd_row_s rows [6] = '{'{8'h00, 1'b0, 1'b1}, '{8'h41, 1'b0, 1'b1}, '{8'h82, 1'b1, 1'b0},
                          '{8'hc3, 1'b0, 1'b1}, '{8'h80, 1'b1, 1'b1}, '{8'h3e, 1'b0, 1'b0}};

  always #5 clk = ~clk;

  fsd_flash_security_decode #(.INDEX_W(3)) uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .nvm_sec_byte(nvm_sec_byte),
    .backdoor_unlock(backdoor_unlock),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data),
    .backdoor_enabled(backdoor_enabled),
    .secured(secured),
    .sec_loaded(sec_loaded),
    .param_index(param_index)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rd_data, exp);
  endtask

  // byte is held stable across release so the capture sees it
  task automatic rst(input logic [7:0] b);
    @(posedge clk);
    sys_rst <= 1'b1;
    nvm_sec_byte <= b;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk({5'h00, secured, backdoor_enabled, sec_loaded}, 8'h04);
    chk({5'h00, param_index}, 8'h00);
    chk(reg_rd_data, 8'h00);
    foreach (rows[i]) begin
      rst(rows[i].sec_byte);
      chk({6'h00, backdoor_enabled, secured}, {6'h00, rows[i].be, rows[i].sec});
      rd_chk(OFF_SEC_BYTE, rows[i].sec_byte);
      rd_chk(OFF_STATUS, {4'h0, 1'b0, 1'b1, rows[i].sec, rows[i].be});
    end
    // later changes of the nonvolatile byte must not leak through
    @(posedge clk);
    nvm_sec_byte <= 8'h82;
    repeat (3) @(posedge clk);
    #1;
    chk({6'h00, backdoor_enabled, secured}, 8'h00);
    wr(OFF_SEC_BYTE, 8'h82);
    rd_chk(OFF_SEC_BYTE, 8'h3e);
    // index field only; write then read with one idle cycle between
    wr(OFF_PARAM_IDX, 8'hff);
    rd_chk(OFF_PARAM_IDX, IMASK);
    wr(OFF_PARAM_IDX, 8'h05);
    #1;
    chk({5'h00, param_index}, 8'h05);
    rd_chk(OFF_PARAM_IDX, 8'h05);
    @(posedge clk);
    #1;
    chk(reg_rd_data, 8'h00);
    wr(8'h40, 8'ha5);
    rd_chk(8'h40, 8'h00);
    chk({5'h00, param_index}, 8'h05);
    // write strobe followed by read strobe with no gap
    @(posedge clk);
    reg_addr <= OFF_PARAM_IDX;
    reg_wr_data <= 8'h03;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rd_data, 8'h03);
    chk({5'h00, param_index}, 8'h03);
    // unlock overrides a secured byte and sticks until reset
    rst(8'h41);
    @(posedge clk);
    backdoor_unlock <= 1'b1;
    @(posedge clk);
    backdoor_unlock <= 1'b0;
    #1;
    chk({7'h00, secured}, 8'h00);
    rd_chk(OFF_SEC_BYTE, 8'h42);
    rd_chk(OFF_STATUS, 8'h0c);
    rst(8'h41);
    chk({7'h00, secured}, 8'h01);
    print_verdict();
  end
endmodule
